// ---- logic/rbc_cfg.svh ----
// register map, field positions, reset values and timing figures of the rate bias/alarm block
`ifndef RBC_CFG_SVH
`define RBC_CFG_SVH

`define RBC_ADDR_OFF_FINE   7'h08
`define RBC_ADDR_OFF_COARSE 7'h0a
`define RBC_ADDR_THR1       7'h10
`define RBC_ADDR_THR2       7'h12
`define RBC_ADDR_WIN1       7'h14
`define RBC_ADDR_WIN2       7'h16
`define RBC_ADDR_ALM_CFG    7'h18
`define RBC_ADDR_DIAG       7'h26
`define RBC_ADDR_CMD        7'h28

`define RBC_REG_RESET       16'h0000

`define RBC_CMD_AUTONULL    0
`define RBC_CMD_RESTORE     1

`define RBC_SRC1_LO         8
`define RBC_SRC_W           4
`define RBC_MODE1           6
`define RBC_POL1            4
`define RBC_FILT            3
`define RBC_IND_EN          2
`define RBC_IND_POL         1
`define RBC_IND_SEL         0
`define RBC_DIAG_ALM1       8

`define RBC_SRC_OFF         4'h0
`define RBC_SRC_RATE        4'h1
`define RBC_SRC_TEMP        4'h2
`define RBC_SRC_DIAG        4'h3

`define RBC_DEC_MAX         16
`define RBC_FRAME_BITS      5'd16

`define RBC_CLK_PERIOD_NS   20
`define RBC_FLASH_TIME_US   70000
`define RBC_RESTORE_MAX_US  72000

`endif

// ---- logic/rbc_pkg.sv ----
// types shared by the rate bias calibration and alarm block
package rbc_pkg;
  typedef logic [15:0] rbc_word_t;
  typedef logic [4:0]  rbc_dec_t;
  typedef enum logic [2:0] {
    RBC_IDLE,
    RBC_AN_SYNC,
    RBC_AN_ACC,
    RBC_AN_STORE,
    RBC_FLASH
  } rbc_state_e;
endpackage

// ---- logic/rbc_top.sv ----
// rate bias calibration (autonull, manual offsets, restore) and two-channel alarm logic
`include "rbc_cfg.svh"

module rbc_top #(
  parameter int FLASH_CYCLES = `RBC_FLASH_TIME_US * 1000 / `RBC_CLK_PERIOD_NS,
  parameter int DEC_MAX      = `RBC_DEC_MAX
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              spi_cs_n,
  input  wire logic              spi_sclk,
  input  wire logic              spi_mosi,
  output logic                   spi_miso,
  output logic                   spi_miso_oe_n,
  input  wire logic              sample_valid,
  input  wire rbc_pkg::rbc_word_t rate_raw_coarse,
  input  wire rbc_pkg::rbc_word_t rate_raw_fine,
  input  wire rbc_pkg::rbc_word_t rate_filt_coarse,
  input  wire rbc_pkg::rbc_word_t temp_in,
  input  wire rbc_pkg::rbc_word_t diag_in,
  input  wire rbc_pkg::rbc_dec_t  decimation_setting,
  input  wire logic              drdy_enable,
  input  wire logic              drdy_line,
  input  wire logic              drdy_level,
  output rbc_pkg::rbc_word_t     rate_output_coarse,
  output rbc_pkg::rbc_word_t     rate_output_fine,
  output logic                   data_clear,
  output logic                   flash_write,
  output logic                   seq_busy,
  output logic                   aux_line_one,
  output logic                   aux_line_one_oe_n,
  output logic                   aux_line_two,
  output logic                   aux_line_two_oe_n
);
  import rbc_pkg::*;

  localparam int FT_W = $clog2(FLASH_CYCLES + 1);

  if (FLASH_CYCLES < 1 ||
      FLASH_CYCLES > `RBC_RESTORE_MAX_US * 1000 / `RBC_CLK_PERIOD_NS) begin : g_bad_flash
    $error("flash commit time exceeds the restore limit");
  end
  if (DEC_MAX < 0 || DEC_MAX > `RBC_DEC_MAX) begin : g_bad_dec
    $error("decimation maximum out of range");
  end

  function automatic logic [15:0] byte_merge(input logic [15:0] old, input logic odd,
                                             input logic [7:0] d);
    byte_merge = odd ? {d, old[7:0]} : {old[15:8], d};
  endfunction

  function automatic logic same_word(input logic [6:0] a, input logic [6:0] base);
    same_word = (a[6:1] == base[6:1]);
  endfunction

  // unsigned compare only for the status-word source
  function automatic logic cmp_hit(input logic [15:0] v, input logic [15:0] t,
                                   input logic above, input logic uns);
    if (uns)
      cmp_hit = above ? (v > t) : (v < t);
    else
      cmp_hit = above ? ($signed(v) > $signed(t)) : ($signed(v) < $signed(t));
  endfunction

  // reset release through two flops
  logic [1:0] rst_q;
  logic       rst_n;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      rst_q <= 2'b00;
    else
      rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1];

  // pin synchronisers; stage 2 is only an edge-detect history
  logic [2:0] cs_s;
  logic [2:0] sck_s;
  logic [1:0] mosi_s;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_s   <= 3'h7;
      sck_s  <= 3'h7;
      mosi_s <= 2'h0;
    end else begin
      cs_s   <= {cs_s[1:0], spi_cs_n};
      sck_s  <= {sck_s[1:0], spi_sclk};
      mosi_s <= {mosi_s[0], spi_mosi};
    end
  end

  logic sck_rise, sck_fall, cs_fall, cs_rise;
  assign sck_rise = sck_s[1] & ~sck_s[2];
  assign sck_fall = ~sck_s[1] & sck_s[2];
  assign cs_fall  = ~cs_s[1] & cs_s[2];
  assign cs_rise  = cs_s[1] & ~cs_s[2];

  rbc_state_e  state;
  logic        busy;
  assign busy = (state != RBC_IDLE);

  logic [15:0] rx;
  logic [4:0]  bitcnt;
  logic [15:0] tx;
  logic        frame_done, wr;
  logic [6:0]  addr;
  logic [7:0]  wdata;

  assign frame_done = cs_rise && (bitcnt == `RBC_FRAME_BITS) && !busy;
  assign wr    = frame_done & rx[15];
  assign addr  = rx[14:8];
  assign wdata = rx[7:0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx     <= 16'h0000;
      bitcnt <= 5'h00;
    end else if (cs_fall) begin
      bitcnt <= 5'h00;
    end else if (!cs_s[1] && sck_rise && bitcnt != `RBC_FRAME_BITS) begin
      rx     <= {rx[14:0], mosi_s[1]};
      bitcnt <= bitcnt + 5'h01;
    end
  end

  // configuration and offset storage
  logic [15:0] off_c, off_f, alm_cfg;
  logic [15:0] thr [2];
  logic [15:0] win [2];
  logic [1:0]  cmd;
  logic [1:0]  flag;

  function automatic logic [15:0] read_word(input logic [6:0] a);
    if (same_word(a, `RBC_ADDR_OFF_FINE))        read_word = off_f;
    else if (same_word(a, `RBC_ADDR_OFF_COARSE)) read_word = off_c;
    else if (same_word(a, `RBC_ADDR_THR1))       read_word = thr[0];
    else if (same_word(a, `RBC_ADDR_THR2))       read_word = thr[1];
    else if (same_word(a, `RBC_ADDR_WIN1))       read_word = win[0];
    else if (same_word(a, `RBC_ADDR_WIN2))       read_word = win[1];
    else if (same_word(a, `RBC_ADDR_ALM_CFG))    read_word = alm_cfg;
    else if (same_word(a, `RBC_ADDR_DIAG))
      read_word = {diag_in[15:10], flag, diag_in[7:0]};
    else if (same_word(a, `RBC_ADDR_CMD))        read_word = {14'h0000, cmd};
    else                                         read_word = 16'h0000;
  endfunction

  // read data is shifted out during the following frame, msb first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx <= 16'h0000;
    end else if (cs_rise) begin
      tx <= (frame_done && !rx[15]) ? read_word(addr) : 16'h0000;
    end else if (!cs_s[1] && sck_fall && bitcnt != 5'h00) begin
      tx <= {tx[14:0], 1'b0};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spi_miso      <= 1'b0;
      spi_miso_oe_n <= 1'b1;
    end else begin
      spi_miso      <= tx[15];
      spi_miso_oe_n <= cs_s[1];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alm_cfg <= `RBC_REG_RESET;
      thr[0]  <= `RBC_REG_RESET;
      thr[1]  <= `RBC_REG_RESET;
      win[0]  <= `RBC_REG_RESET;
      win[1]  <= `RBC_REG_RESET;
    end else if (wr) begin
      if (same_word(addr, `RBC_ADDR_ALM_CFG)) alm_cfg <= byte_merge(alm_cfg, addr[0], wdata);
      if (same_word(addr, `RBC_ADDR_THR1))    thr[0]  <= byte_merge(thr[0], addr[0], wdata);
      if (same_word(addr, `RBC_ADDR_THR2))    thr[1]  <= byte_merge(thr[1], addr[0], wdata);
      if (same_word(addr, `RBC_ADDR_WIN1))    win[0]  <= byte_merge(win[0], addr[0], wdata);
      if (same_word(addr, `RBC_ADDR_WIN2))    win[1]  <= byte_merge(win[1], addr[0], wdata);
    end
  end

  // corrected output: coarse and fine form one 32-bit word so the fine carry reaches coarse
  logic [31:0] combined;
  assign combined = {rate_raw_coarse, rate_raw_fine} + {off_c, off_f};

  logic        cmd_wr, do_restore;
  assign cmd_wr     = wr && addr == `RBC_ADDR_CMD;
  assign do_restore = cmd_wr && wdata[`RBC_CMD_RESTORE];

  logic [4:0]  dec_eff;
  logic [16:0] an_cnt;
  logic [47:0] acc, avg;
  logic [31:0] neg_avg;
  logic [FT_W-1:0] ftimer;
  assign dec_eff = (decimation_setting > 5'(DEC_MAX)) ? 5'(DEC_MAX) : decimation_setting;
  assign avg     = 48'($signed(acc) >>> dec_eff);
  assign neg_avg = 32'h0000_0000 - avg[31:0];

  // sequencer owns the offsets, the command bits and the flash commit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= RBC_IDLE;
      cmd         <= 2'b00;
      off_c       <= `RBC_REG_RESET;
      off_f       <= `RBC_REG_RESET;
      acc         <= 48'h0;
      an_cnt      <= 17'h0;
      ftimer      <= '0;
      flash_write <= 1'b0;
      data_clear  <= 1'b0;
    end else begin
      flash_write <= 1'b0;
      data_clear  <= 1'b0;
      case (state)
        RBC_IDLE: begin
          if (wr && same_word(addr, `RBC_ADDR_OFF_FINE))
            off_f <= byte_merge(off_f, addr[0], wdata);
          if (wr && same_word(addr, `RBC_ADDR_OFF_COARSE))
            off_c <= byte_merge(off_c, addr[0], wdata);
          if (do_restore) begin
            off_c       <= `RBC_REG_RESET;
            off_f       <= `RBC_REG_RESET;
            data_clear  <= 1'b1;
            flash_write <= 1'b1;
            ftimer      <= FT_W'(FLASH_CYCLES);
            cmd         <= 2'b10;
            state       <= RBC_FLASH;
          end else if (cmd_wr && wdata[`RBC_CMD_AUTONULL]) begin
            cmd   <= 2'b01;
            state <= RBC_AN_SYNC;
          end
        end
        RBC_AN_SYNC: begin
          // restart the averaging cycle on the next sample
          if (sample_valid) begin
            acc    <= 48'h0;
            an_cnt <= 17'h0;
            state  <= RBC_AN_ACC;
          end
        end
        RBC_AN_ACC: begin
          if (sample_valid) begin
            acc    <= acc + {{16{combined[31]}}, combined};
            an_cnt <= an_cnt + 17'h1;
            if (an_cnt + 17'h1 == (17'h1 << dec_eff))
              state <= RBC_AN_STORE;
          end
        end
        RBC_AN_STORE: begin
          off_c       <= neg_avg[31:16];
          off_f       <= neg_avg[15:0];
          flash_write <= 1'b1;
          ftimer      <= FT_W'(FLASH_CYCLES);
          state       <= RBC_FLASH;
        end
        RBC_FLASH: begin
          ftimer <= ftimer - FT_W'(1);
          if (ftimer <= FT_W'(1)) begin
            cmd   <= 2'b00;
            state <= RBC_IDLE;
          end
        end
        default: state <= RBC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_output_coarse <= 16'h0000;
      rate_output_fine   <= 16'h0000;
      seq_busy           <= 1'b0;
    end else begin
      seq_busy <= busy;
      if (data_clear) begin
        rate_output_coarse <= 16'h0000;
        rate_output_fine   <= 16'h0000;
      end else if (sample_valid) begin
        rate_output_coarse <= combined[31:16];
        rate_output_fine   <= combined[15:0];
      end
    end
  end

  // alarm sources
  logic [15:0] coarse_src;
  logic [15:0] diag_word;
  logic [3:0]  src  [2];
  logic [15:0] sval [2];
  assign coarse_src = alm_cfg[`RBC_FILT] ? rate_filt_coarse + off_c : combined[31:16];
  assign diag_word  = {diag_in[15:10], flag, diag_in[7:0]};

  for (genvar i = 0; i < 2; i++) begin : g_src
    assign src[i] = alm_cfg[`RBC_SRC1_LO + i*`RBC_SRC_W +: `RBC_SRC_W];
    always_comb begin
      case (src[i])
        `RBC_SRC_RATE: sval[i] = coarse_src;
        `RBC_SRC_TEMP: sval[i] = temp_in;
        `RBC_SRC_DIAG: sval[i] = diag_word;
        default:       sval[i] = 16'h0000;
      endcase
    end
  end

  logic [7:0]  wcnt [2];
  logic [15:0] ref_v [2];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag  <= 2'b00;
      wcnt  <= '{8'h00, 8'h00};
      ref_v <= '{16'h0000, 16'h0000};
    end else if (sample_valid) begin
      for (int i = 0; i < 2; i++) begin
        if (src[i] == `RBC_SRC_OFF) begin
          flag[i] <= 1'b0;
          wcnt[i] <= 8'h00;
        end else if (!alm_cfg[`RBC_MODE1 + i]) begin
          flag[i] <= cmp_hit(sval[i], thr[i], alm_cfg[`RBC_POL1 + i],
                             src[i] == `RBC_SRC_DIAG);
        end else if (wcnt[i] + 8'h01 >= ((win[i][7:0] <= 8'h01) ? 8'h01 : win[i][7:0])) begin
          flag[i]  <= cmp_hit(sval[i] - ref_v[i], thr[i], alm_cfg[`RBC_POL1 + i],
                              src[i] == `RBC_SRC_DIAG);
          ref_v[i] <= sval[i];
          wcnt[i]  <= 8'h00;
        end else begin
          wcnt[i] <= wcnt[i] + 8'h01;
        end
      end
    end
  end

  // indicator, yielding to data-ready on a shared line
  logic alm_lvl;
  assign alm_lvl = alm_cfg[`RBC_IND_POL] ? |flag : ~|flag;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_line_one      <= 1'b0;
      aux_line_one_oe_n <= 1'b1;
      aux_line_two      <= 1'b0;
      aux_line_two_oe_n <= 1'b1;
    end else begin
      if (drdy_enable && !drdy_line) begin
        aux_line_one      <= drdy_level;
        aux_line_one_oe_n <= 1'b0;
      end else if (alm_cfg[`RBC_IND_EN] && !alm_cfg[`RBC_IND_SEL]) begin
        aux_line_one      <= alm_lvl;
        aux_line_one_oe_n <= 1'b0;
      end else begin
        aux_line_one      <= 1'b0;
        aux_line_one_oe_n <= 1'b1;
      end
      if (drdy_enable && drdy_line) begin
        aux_line_two      <= drdy_level;
        aux_line_two_oe_n <= 1'b0;
      end else if (alm_cfg[`RBC_IND_EN] && alm_cfg[`RBC_IND_SEL]) begin
        aux_line_two      <= alm_lvl;
        aux_line_two_oe_n <= 1'b0;
      end else begin
        aux_line_two      <= 1'b0;
        aux_line_two_oe_n <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  autonull_start_a: assert property (state == RBC_IDLE && cmd_wr && !do_restore
    && wdata[0] |=> state == RBC_AN_SYNC && cmd == 2'b01) else $error("autonull not started");
  store_then_flash_a: assert property (state == RBC_AN_STORE |=> state == RBC_FLASH
    && flash_write && {off_c, off_f} == $past(neg_avg)) else $error("null store wrong");
  busy_ignores_spi_a: assert property (busy && cs_rise |=> $stable(alm_cfg)
    && $stable(thr[0])) else $error("frame taken while busy");
  window_length_a: assert property (state == RBC_AN_ACC && sample_valid
    && dec_eff == 5'(`RBC_DEC_MAX) && an_cnt != 17'hffff |=> state == RBC_AN_ACC)
    else $error("window ended early");
  output_sum_a: assert property (sample_valid && !data_clear |=>
    {rate_output_coarse, rate_output_fine} == $past(combined)) else $error("offset not summed");
  restore_clears_a: assert property (state == RBC_IDLE && do_restore |=> off_c == 16'h0000
    && off_f == 16'h0000 && data_clear ##1 rate_output_coarse == 16'h0000)
    else $error("restore did not clear");
  cmd_selfclear_a: assert property (state == RBC_FLASH && ftimer == FT_W'(1)
    |=> cmd == 2'b00 && state == RBC_IDLE) else $error("command bit stuck");
  static_flag_a: assert property (sample_valid && src[0] != `RBC_SRC_OFF
    && !alm_cfg[`RBC_MODE1] |=> flag[0] == $past(cmp_hit(sval[0], thr[0],
    alm_cfg[`RBC_POL1], src[0] == `RBC_SRC_DIAG)))
    else $error("static alarm flag wrong");
  alarm_off_a: assert property (sample_valid && src[1] == `RBC_SRC_OFF |=> !flag[1])
    else $error("disabled alarm flagged");
  drdy_priority_a: assert property (drdy_enable && !drdy_line |=> !aux_line_one_oe_n
    && aux_line_one == $past(drdy_level)) else $error("data ready lost line one");
  indicator_two_a: assert property (!(drdy_enable && drdy_line) && alm_cfg[`RBC_IND_EN]
    && alm_cfg[`RBC_IND_SEL] |=> !aux_line_two_oe_n && aux_line_two == $past(alm_lvl))
    else $error("indicator wrong");

  autonull_done_c: cover property (state == RBC_AN_STORE ##1 state == RBC_FLASH);
  restore_done_c:  cover property (do_restore ##[1:10] data_clear);
  alarm_roc_c:     cover property (alm_cfg[7] && flag[1]);
endmodule

// ---- test/rbc_host.sv ----
// host-side SPI master model that reaches the block's registers
module rbc_host (
  input  wire logic clk,
  output logic      spi_cs_n,
  output logic      spi_sclk,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 5; // half sclk period in clk; the block needs at least 4

  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b1;
    spi_mosi = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // mode 3: data changes after falling sclk, both sides take it at rising sclk
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    rx = '0;
    spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      wait_clk(HALF);
      spi_sclk = 1'b0;
      spi_mosi = tx[i];
      wait_clk(HALF);
      spi_sclk = 1'b1;
      rx[i] = spi_miso;
    end
    wait_clk(HALF);
    spi_cs_n = 1'b1;
    // a released line never keeps the last bit, so it cannot pass by luck
    spi_mosi = ~tx[0];
    wait_clk(2 * HALF);
  endtask

  task automatic write_byte(input logic [6:0] addr, input logic [7:0] data);
    logic [15:0] rx;
    frame({1'b1, addr, data}, rx);
  endtask

  // registers are 16 bits wide but written one byte per frame
  task automatic write_word(input logic [6:0] addr, input logic [15:0] data);
    write_byte(addr, data[7:0]);
    write_byte(addr + 7'h01, data[15:8]);
  endtask

  // read data comes back in the frame after the request
  task automatic read_word(input logic [6:0] addr, output logic [15:0] data);
    logic [15:0] rx;
    frame({1'b0, addr, 8'h00}, rx);
    frame(16'h0000, data);
  endtask
endmodule

// ---- test/testbench.sv ----
// self-checking bench: SPI host model, sensor stimulus and scenario tasks
`include "rbc_cfg.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rbc_pkg::*;
  localparam int FLASH_CYC = 8; // flash commit shortened so the run stays short
  logic      clk, resetn, sample_valid, drdy_enable, drdy_line, drdy_level;
  logic      spi_cs_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe_n, miso_line;
  logic      data_clear, flash_write, seq_busy;
  logic      aux_line_one, aux_line_one_oe_n, aux_line_two, aux_line_two_oe_n;
  rbc_word_t rate_raw_coarse, rate_raw_fine, rate_filt_coarse, temp_in, diag_in;
  rbc_word_t rate_output_coarse, rate_output_fine;
  rbc_dec_t  decimation_setting;
  int        err_total, n_tests, flash_cnt, clear_cnt;

  rbc_top #(.FLASH_CYCLES(FLASH_CYC), .DEC_MAX(`RBC_DEC_MAX)) i_rbc_top (
    .clk, .resetn, .spi_cs_n, .spi_sclk, .spi_mosi, .spi_miso, .spi_miso_oe_n,
    .sample_valid, .rate_raw_coarse, .rate_raw_fine, .rate_filt_coarse, .temp_in, .diag_in,
    .decimation_setting, .drdy_enable, .drdy_line, .drdy_level, .rate_output_coarse,
    .rate_output_fine, .data_clear, .flash_write, .seq_busy, .aux_line_one,
    .aux_line_one_oe_n, .aux_line_two, .aux_line_two_oe_n
  );
  // an undriven miso shows the inverse of its last bit
  assign miso_line = spi_miso_oe_n ? ~spi_miso : spi_miso;
  rbc_host i_rbc_host (.clk, .spi_cs_n, .spi_sclk, .spi_mosi, .spi_miso(miso_line));

  always #10 clk = ~clk;
  always @(posedge clk) begin
    flash_cnt += (flash_write === 1'b1);
    clear_cnt += (data_clear === 1'b1);
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic check_word(input string what, input rbc_word_t exp, input rbc_word_t got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wr(input logic [6:0] a, input rbc_word_t d);
    i_rbc_host.write_word(a, d);
  endtask

  task automatic rd(input logic [6:0] a, output rbc_word_t d);
    i_rbc_host.read_word(a, d);
  endtask

  task automatic sample(input rbc_word_t c, input rbc_word_t f);
    rate_raw_coarse = c;
    rate_raw_fine = f;
    sample_valid = 1'b1;
    tick(1);
    sample_valid = 1'b0;
    tick(3);
  endtask

  task automatic flags(output logic [1:0] fl);
    rbc_word_t w;
    rd(`RBC_ADDR_DIAG, w);
    fl = w[9:8];
  endtask

  task automatic test_reset_values();
    rbc_word_t w;
    logic [6:0] regs [8] = '{`RBC_ADDR_OFF_FINE, `RBC_ADDR_OFF_COARSE, `RBC_ADDR_THR1,
      `RBC_ADDR_THR2, `RBC_ADDR_WIN1, `RBC_ADDR_WIN2, `RBC_ADDR_ALM_CFG, 7'h00};
    foreach (regs[i]) begin
      rd(regs[i], w);
      check_word("reset value", `RBC_REG_RESET, w);
    end
    $display("test reset_values done");
  endtask

  task automatic test_static_alarms();
    logic [1:0] fl;
    temp_in = 16'h0200;
    diag_in = 16'h0400;
    wr(`RBC_ADDR_THR1, 16'h0100);
    for (int c = 0; c < 4; c++) begin
      wr(`RBC_ADDR_ALM_CFG, {4'h0, 4'(c), 8'h16});
      sample(16'h0200, 16'h0000);
      flags(fl);
      check_bit("alarm one flag", c != 0, fl[0]);
      check_bit("line one level", c != 0, aux_line_one);
      check_bit("line one enable", 1'b0, aux_line_one_oe_n);
    end
    wr(`RBC_ADDR_THR2, 16'h0300);
    rate_filt_coarse = 16'h0050;
    wr(`RBC_ADDR_ALM_CFG, 16'h210e);
    sample(16'h0200, 16'h0000);
    flags(fl);
    check_word("filtered below", 16'h0003, {14'h0, fl});
    rate_filt_coarse = 16'h0200;
    sample(16'h0050, 16'h0000);
    flags(fl);
    check_word("filtered above", 16'h0002, {14'h0, fl});
    wr(`RBC_ADDR_ALM_CFG, 16'h210d);
    tick(3);
    check_bit("line two low active", 1'b0, aux_line_two);
    check_bit("line one released", 1'b1, aux_line_one_oe_n);
    drdy_enable = 1'b1;
    drdy_line = 1'b1;
    drdy_level = 1'b1;
    tick(3);
    check_bit("line two data ready", 1'b1, aux_line_two);
    drdy_line = 1'b0;
    tick(3);
    check_bit("line one data ready", 1'b1, aux_line_one);
    check_bit("line one driven", 1'b0, aux_line_one_oe_n);
    check_bit("line two alarm back", 1'b0, aux_line_two_oe_n);
    check_bit("line two alarm level", 1'b0, aux_line_two);
    drdy_enable = 1'b0;
    diag_in = 16'hff00;
    wr(`RBC_ADDR_THR2, 16'h0100);
    wr(`RBC_ADDR_ALM_CFG, 16'h3130);
    sample(16'hff00, 16'h0000);
    flags(fl);
    check_word("signed and unsigned", 16'h0002, {14'h0, fl});
    $display("test static_alarms done");
  endtask

  task automatic test_roc(input logic [7:0] win);
    logic [1:0] fl;
    int n = (win < 8'd2) ? 1 : int'(win);
    wr(`RBC_ADDR_THR1, 16'h0100);
    wr(`RBC_ADDR_WIN1, {8'h00, win});
    // one-sample windows also run alarm two in rate-of-change; its window register stays 0
    wr(`RBC_ADDR_ALM_CFG, (win < 8'h02) ? 16'h11f0 : 16'h0150);
    repeat (2 * n) sample(16'h1000, 16'h0000);
    flags(fl);
    check_word("steady change", 16'h0000, {14'h0, fl});
    repeat (n) sample(16'h1200, 16'h0000);
    flags(fl);
    check_word("step change", {14'h0, (win < 8'h02), 1'b1}, {14'h0, fl});
    repeat (n) sample(16'h1200, 16'h0000);
    flags(fl);
    check_word("change gone", 16'h0000, {14'h0, fl});
    $display("test roc window %0d done", win);
  endtask

  task automatic test_offsets();
    rbc_word_t w;
    logic [31:0] s;
    s = {16'h0010, 16'h8000} + {16'hfffe, 16'hc000};
    wr(`RBC_ADDR_OFF_FINE, 16'hc000);
    wr(`RBC_ADDR_OFF_COARSE, 16'hfffe);
    rd(`RBC_ADDR_OFF_FINE, w);
    check_word("fine offset", 16'hc000, w);
    sample(16'h0010, 16'h8000);
    check_word("coarse output", s[31:16], rate_output_coarse);
    check_word("fine output", s[15:0], rate_output_fine);
    $display("test offsets done");
  endtask

  task automatic test_autonull();
    rbc_word_t w;
    logic [31:0] nul;
    int k;
    int f0;
    nul = -{16'h0010, 16'h8000};
    decimation_setting = 5'd2;
    wr(`RBC_ADDR_OFF_FINE, 16'h0000);
    wr(`RBC_ADDR_OFF_COARSE, 16'h0000);
    f0 = flash_cnt;
    i_rbc_host.write_byte(`RBC_ADDR_CMD, 8'h01);
    tick(4);
    check_bit("null busy", 1'b1, seq_busy);
    wr(`RBC_ADDR_WIN2, 16'h0055);
    k = 0;
    while (seq_busy === 1'b1 && k < 40) begin
      sample(16'h0010, 16'h8000);
      k++;
    end
    check_bit("null finished", 1'b0, seq_busy);
    check_word("null flash", 16'(f0 + 1), 16'(flash_cnt));
    rd(`RBC_ADDR_OFF_COARSE, w);
    check_word("null coarse", nul[31:16], w);
    rd(`RBC_ADDR_OFF_FINE, w);
    check_word("null fine", nul[15:0], w);
    rd(`RBC_ADDR_WIN2, w);
    check_word("ignored write", 16'h0000, w);
    rd(`RBC_ADDR_CMD, w);
    check_word("command cleared", 16'h0000, w);
    $display("test autonull done");
  endtask

  task automatic test_restore();
    rbc_word_t w;
    int f0;
    int c0;
    wr(`RBC_ADDR_OFF_COARSE, 16'h1234);
    sample(16'h0100, 16'h0000);
    f0 = flash_cnt;
    c0 = clear_cnt;
    i_rbc_host.write_byte(`RBC_ADDR_CMD, 8'h02);
    tick(FLASH_CYC + 4);
    check_word("restore flash", 16'(f0 + 1), 16'(flash_cnt));
    check_word("restore clear", 16'(c0 + 1), 16'(clear_cnt));
    check_word("data zeroed", 16'h0000, rate_output_coarse);
    rd(`RBC_ADDR_OFF_COARSE, w);
    check_word("offset zeroed", 16'h0000, w);
    rd(`RBC_ADDR_CMD, w);
    check_word("restore cleared", 16'h0000, w);
    i_rbc_host.write_byte(`RBC_ADDR_CMD, 8'h01);
    tick(4);
    check_bit("null waiting", 1'b1, seq_busy);
    resetn = 1'b0;
    tick(2);
    resetn = 1'b1;
    tick(5);
    check_bit("null aborted", 1'b0, seq_busy);
    $display("test restore done");
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    sample_valid = 1'b0;
    rate_raw_coarse = 16'h0000;
    rate_raw_fine = 16'h0000;
    rate_filt_coarse = 16'h0000;
    temp_in = 16'h0000;
    diag_in = 16'h0000;
    decimation_setting = 5'd0;
    drdy_enable = 1'b0;
    drdy_line = 1'b0;
    drdy_level = 1'b0;
    tick(8);
    resetn = 1'b1;
    tick(5);
    test_reset_values();
    test_static_alarms();
    test_roc(8'h00);
    test_roc(8'h01);
    test_roc(8'h03);
    test_offsets();
    test_autonull();
    test_restore();
    report_and_stop();
  end

  // the scenarios need about 20,300 cycles; this leaves ample margin
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    $display("BAD watchdog expected finish seen timeout");
    report_and_stop();
  end
endmodule
